// ==== verilog/esgp_pkg.sv ====
`default_nettype none
package esgp_pkg;
    // Port width and register reset values
    localparam int PORT_W = 8;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic PULL_RESET = 1'b0;
    localparam logic DRIVE_RESET = 1'b0;

    // Register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_DATA = 5'h00;
    localparam logic [4:0] OFF_DIR = 5'h04;
    localparam logic [4:0] OFF_PULL = 5'h08;
    localparam logic [4:0] OFF_DRIVE = 5'h0c;
    localparam logic [4:0] OFF_STATUS = 5'h10;

    // Field positions
    localparam int PULL_EN_BIT = 0;
    localparam int DRIVE_RED_BIT = 0;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_MODE_MSB = 1;
    localparam int STAT_LOCK_BIT = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Chip operating mode
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_EXPANDED,
        MODE_PERIPHERAL
    } esgp_mode_t;
endpackage : esgp_pkg
`default_nettype wire

// ==== verilog/esgp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module esgp_sync (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Asynchronous input and its synchronised copy
    input wire logic [esgp_pkg::PORT_W-1:0] asyncIn,
    output logic [esgp_pkg::PORT_W-1:0] syncOut
);
    import esgp_pkg::*;

    logic [PORT_W-1:0] stage1_reg;
    logic [PORT_W-1:0] stage2_reg;

    // Two flip-flops per pin; only the second stage is read
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else if (ce) begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule : esgp_sync
`default_nettype wire

// ==== verilog/esgp_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Data register is readable and writable whenever it is in the map.
// - Every port pin has its own direction bit.
// - After reset every pin is an input.
// - In expanded mode the pins carry the external address/data bus.
// - In single-chip mode the pins are software general-purpose I/O.
// - Data register is absent from the map in expanded and peripheral mode.
// - Direction register is absent in expanded and peripheral mode.
// - Direction bit set makes the pin an output, cleared an input.
// - Direction register resets to all zeros.
// - Pull-up enable bit pulls up every input pin.
// - Pull-ups stay inactive while the port serves the expanded bus.
// - Reduced-drive bit switches all port outputs to reduced drive.
// - Drive control register accepts one write after reset only.
// - Drive control register is absent in peripheral mode.
module esgp_port (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Chip operating mode
    input wire esgp_pkg::esgp_mode_t opMode,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [esgp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [esgp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Port pins
    input wire logic [esgp_pkg::PORT_W-1:0] padIn,
    output logic [esgp_pkg::PORT_W-1:0] padOut,
    output logic [esgp_pkg::PORT_W-1:0] padOe,
    output logic [esgp_pkg::PORT_W-1:0] padPullup,
    output logic padReducedDrive,
    // External bus side
    input wire logic [esgp_pkg::PORT_W-1:0] extBusOut,
    input wire logic [esgp_pkg::PORT_W-1:0] extBusOe,
    output logic [esgp_pkg::PORT_W-1:0] extBusIn
);
    import esgp_pkg::*;

    // Register state
    logic [PORT_W-1:0] portData_reg;
    logic [PORT_W-1:0] shared_port_direction_reg;
    logic shared_port_pullup_enable;
    logic shared_port_reduced_drive;
    logic driveLocked_reg;

    // AXI write side state
    logic awHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic wHeld_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    // AXI read side state
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Pin side state
    logic [PORT_W-1:0] pinSync;
    logic [PORT_W-1:0] padOut_reg;
    logic [PORT_W-1:0] padOe_reg;
    logic [PORT_W-1:0] padPullup_reg;
    logic padReducedDrive_reg;

    // Decode helpers
    logic isExpanded;
    logic portMapped;
    logic driveMapped;
    logic doWrite;
    logic lowLane;
    logic [PORT_W-1:0] portReadValue;
    logic [PORT_W-1:0] padOut_next;
    logic [PORT_W-1:0] padOe_next;
    logic [PORT_W-1:0] padPullup_next;
    logic [31:0] readData;
    logic [1:0] readResp;
    logic [1:0] writeResp;
    logic dataWrite;
    logic dirWrite;
    logic pullWrite;
    logic driveWrite;

    esgp_sync u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .asyncIn(padIn),
        .syncOut(pinSync)
    );

    assign isExpanded = (opMode == MODE_EXPANDED);
    assign portMapped = (opMode == MODE_SINGLE);
    assign driveMapped = (opMode != MODE_PERIPHERAL);

    // Inputs show the pin, outputs the latch
    assign portReadValue = (portData_reg & shared_port_direction_reg) |
                           (pinSync & ~shared_port_direction_reg);

    // AXI handshakes; all frozen while ce is low
    assign s_axi_awready = ce && !awHeld_reg && !bvalid_reg;
    assign s_axi_wready = ce && !wHeld_reg && !bvalid_reg;
    assign s_axi_arready = ce && !rvalid_reg;
    assign doWrite = ce && awHeld_reg && wHeld_reg && !bvalid_reg;
    assign lowLane = wStrb_reg[0];

    // Write address capture
    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_reg <= 1'b0;
            end
        end
    end

    // Write data capture
    always_ff @(posedge clk) begin
        if (rst) begin
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_reg <= 1'b0;
            end
        end
    end

    // Write response decode
    always_comb begin
        if (awAddr_reg == OFF_DATA || awAddr_reg == OFF_DIR) begin
            writeResp = portMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (awAddr_reg == OFF_PULL) begin
            writeResp = RESP_OKAY;
        end else if (awAddr_reg == OFF_DRIVE) begin
            writeResp = driveMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (awAddr_reg == OFF_STATUS) begin
            writeResp = RESP_OKAY;
        end else begin
            writeResp = RESP_DECERR;
        end
    end

    // Per-register write strobes
    always_comb begin
        dataWrite = 1'b0;
        dirWrite = 1'b0;
        pullWrite = 1'b0;
        driveWrite = 1'b0;
        if (doWrite && lowLane) begin
            if (awAddr_reg == OFF_DATA) begin
                dataWrite = portMapped;
            end else if (awAddr_reg == OFF_DIR) begin
                dirWrite = portMapped;
            end else if (awAddr_reg == OFF_PULL) begin
                pullWrite = 1'b1;
            end else if (awAddr_reg == OFF_DRIVE) begin
                driveWrite = driveMapped;
            end
        end
    end

    // Write response channel
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (ce) begin
            if (doWrite) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= writeResp;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Port data latch
    always_ff @(posedge clk) begin
        if (rst) begin
            portData_reg <= DATA_RESET;
        end else if (ce && dataWrite) begin
            portData_reg <= wData_reg[PORT_W-1:0];
        end
    end

    // Direction register, one bit per pin
    always_ff @(posedge clk) begin
        if (rst) begin
            shared_port_direction_reg <= DIR_RESET;
        end else if (ce && dirWrite) begin
            shared_port_direction_reg <= wData_reg[PORT_W-1:0];
        end
    end

    // Pull-up control register
    always_ff @(posedge clk) begin
        if (rst) begin
            shared_port_pullup_enable <= PULL_RESET;
        end else if (ce && pullWrite) begin
            shared_port_pullup_enable <= wData_reg[PULL_EN_BIT];
        end
    end

    // Drive control register, write once after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            shared_port_reduced_drive <= DRIVE_RESET;
            driveLocked_reg <= 1'b0;
        end else if (ce && driveWrite) begin
            if (!driveLocked_reg) begin
                shared_port_reduced_drive <= wData_reg[DRIVE_RED_BIT];
                driveLocked_reg <= 1'b1;
            end
        end
    end

    // Read decode
    always_comb begin
        readData = '0;
        readResp = RESP_OKAY;
        if (s_axi_araddr == OFF_DATA) begin
            if (portMapped) begin
                readData[PORT_W-1:0] = portReadValue;
            end else begin
                readResp = RESP_SLVERR;
            end
        end else if (s_axi_araddr == OFF_DIR) begin
            if (portMapped) begin
                readData[PORT_W-1:0] = shared_port_direction_reg;
            end else begin
                readResp = RESP_SLVERR;
            end
        end else if (s_axi_araddr == OFF_PULL) begin
            readData[PULL_EN_BIT] = shared_port_pullup_enable;
        end else if (s_axi_araddr == OFF_DRIVE) begin
            if (driveMapped) begin
                readData[DRIVE_RED_BIT] = shared_port_reduced_drive;
            end else begin
                readResp = RESP_SLVERR;
            end
        end else if (s_axi_araddr == OFF_STATUS) begin
            readData[STAT_MODE_MSB:STAT_MODE_LSB] = opMode;
            readData[STAT_LOCK_BIT] = driveLocked_reg;
        end else begin
            readResp = RESP_DECERR;
        end
    end

    // Read data channel
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= readData;
                rresp_reg <= readResp;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Per-pin function select
    genvar i;
    generate
        for (i = 0; i < PORT_W; i = i + 1) begin : g_pin
            always_comb begin
                if (isExpanded) begin
                    padOut_next[i] = extBusOut[i];
                    padOe_next[i] = extBusOe[i];
                    padPullup_next[i] = 1'b0;
                end else begin
                    padOut_next[i] = portData_reg[i];
                    padOe_next[i] = shared_port_direction_reg[i];
                    padPullup_next[i] = shared_port_pullup_enable &&
                                        !shared_port_direction_reg[i];
                end
            end
        end
    endgenerate

    // Registered pin drive
    always_ff @(posedge clk) begin
        if (rst) begin
            padOut_reg <= '0;
            padOe_reg <= '0;
            padPullup_reg <= '0;
            padReducedDrive_reg <= 1'b0;
        end else if (ce) begin
            padOut_reg <= padOut_next;
            padOe_reg <= padOe_next;
            padPullup_reg <= padPullup_next;
            padReducedDrive_reg <= shared_port_reduced_drive;
        end
    end

    assign padOut = padOut_reg;
    assign padOe = padOe_reg;
    assign padPullup = padPullup_reg;
    assign padReducedDrive = padReducedDrive_reg;
    assign extBusIn = pinSync;

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule : esgp_port
`default_nettype wire

// ==== tb/esgp_port_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module esgp_port_properties (
    // Clock and mode
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire esgp_pkg::esgp_mode_t opMode,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [esgp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [esgp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Pins
    input wire logic [esgp_pkg::PORT_W-1:0] padOut,
    input wire logic [esgp_pkg::PORT_W-1:0] padOe,
    input wire logic [esgp_pkg::PORT_W-1:0] padPullup,
    input wire logic [esgp_pkg::PORT_W-1:0] extBusOut,
    input wire logic [esgp_pkg::PORT_W-1:0] extBusOe
);
    import esgp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_absent;
        s_wr_both ##0 (s_axi_awaddr == OFF_DATA && opMode != MODE_SINGLE);
    endsequence
    a_reset_inputs: assert property (
        $fell(rst) |-> padOe == '0 && padPullup == '0) else $error("pins not inputs");
    a_bus_pins: assert property (
        ce && opMode == MODE_EXPANDED |=> padOut == $past(extBusOut) && padOe == $past(extBusOe))
        else $error("bus not on pins");
    a_bus_nopull: assert property (
        ce && opMode == MODE_EXPANDED |=> padPullup == '0) else $error("pull-up on bus");
    a_pull_inputs: assert property (
        ce && opMode == MODE_SINGLE |=> padPullup == '0 || padPullup == ~padOe)
        else $error("pull on output");
    a_write_answer: assert property (
        s_wr_both |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_data_absent: assert property (
        s_wr_absent |-> ##2 s_axi_bresp == RESP_SLVERR) else $error("data write accepted");
    a_dir_absent: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_DIR && opMode != MODE_SINGLE
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0) else $error("direction mapped");
endmodule : esgp_port_properties
bind esgp_port esgp_port_properties i_props (.*);
`default_nettype wire

// ==== tb/esgp_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module esgp_pin_model (
    // Clock
    input wire logic clk,
    // Design drive
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] padPullup,
    // Outside drive
    input wire logic [7:0] extVal,
    input wire logic [7:0] extOe,
    // Pin level
    output logic [7:0] padIn
);
    logic [7:0] noise = 8'h55;
    // Floating bits change every cycle
    always_ff @(posedge clk) begin
        noise <= ~noise;
    end
    assign padIn = (padOe & padOut) | (~padOe & extOe & extVal)
        | (~padOe & ~extOe & (padPullup | noise));
endmodule : esgp_pin_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import esgp_pkg::*;
    logic clk, rst = 1'b1, ce = 1'b1;
    esgp_mode_t opMode = MODE_SINGLE;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [ADDR_W-1:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] padIn, padOut, padOe, padPullup, extBusIn;
    logic [7:0] extBusOut = 8'h96, extBusOe = 8'h5a, extVal = 8'h3c, extOe = 8'hff;
    logic padReducedDrive;
    int n_errors = 0;
    int samples_checked = 0;

    esgp_port i_dut (.*);
    esgp_pin_model i_pins (.clk(clk), .padOut(padOut), .padOe(padOe),
        .padPullup(padPullup), .extVal(extVal), .extOe(extOe), .padIn(padIn));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aok, wok, bok;
        logic [1:0] r;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            aok = s_axi_awvalid && s_axi_awready;
            wok = s_axi_wvalid && s_axi_wready;
            bok = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aok) s_axi_awvalid <= 1'b0;
            if (wok) s_axi_wvalid <= 1'b0;
        end while (bok !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(r), 32'(er));
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic aok, rok;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            aok = s_axi_arvalid && s_axi_arready;
            rok = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (aok) s_axi_arvalid <= 1'b0;
        end while (rok !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(d, ed);
        chk(32'(r), 32'(er));
    endtask : rd

    task automatic t_gpio();
        @(negedge clk);
        chk(32'({padOe, padPullup, 7'h0, padReducedDrive}), 32'h0);
        rd(OFF_DIR, 32'h0, RESP_OKAY);
        rd(OFF_DATA, 32'h3c, RESP_OKAY);
        wr(OFF_DIR, 32'hf0, RESP_OKAY);
        wr(OFF_DATA, 32'ha5, RESP_OKAY);
        @(negedge clk);
        chk(32'({padOe, padOut}), 32'hf0a5);
        rd(OFF_DATA, 32'hac, RESP_OKAY);
        wr(OFF_PULL, 32'h1, RESP_OKAY);
        @(negedge clk);
        chk(32'(padPullup), 32'h0f);
    endtask : t_gpio

    task automatic t_exp();
        @(posedge clk);
        opMode <= MODE_EXPANDED;
        repeat (2) @(negedge clk);
        chk(32'({padOut, padOe, padPullup}), 32'h965a00);
        wr(OFF_DATA, 32'h11, RESP_SLVERR);
        wr(OFF_DIR, 32'h11, RESP_SLVERR);
        @(negedge clk);
        chk(32'(extBusIn), 32'h36);
        rd(OFF_DIR, 32'h0, RESP_SLVERR);
        @(posedge clk);
        opMode <= MODE_SINGLE;
        rd(OFF_DIR, 32'hf0, RESP_OKAY);
        rd(OFF_DATA, 32'hac, RESP_OKAY);
    endtask : t_exp

    task automatic t_drive();
        wr(OFF_DRIVE, 32'h1, RESP_OKAY);
        @(negedge clk);
        chk(32'(padReducedDrive), 32'h1);
        wr(OFF_DRIVE, 32'h0, RESP_OKAY);
        rd(OFF_DRIVE, 32'h1, RESP_OKAY);
        @(posedge clk);
        opMode <= MODE_PERIPHERAL;
        wr(OFF_DRIVE, 32'h0, RESP_SLVERR);
        rd(OFF_DATA, 32'h0, RESP_SLVERR);
        rd(OFF_STATUS, 32'(MODE_PERIPHERAL) | 32'(1 << STAT_LOCK_BIT), RESP_OKAY);
        wr(5'h14, 32'h0, RESP_DECERR);
    endtask : t_drive

    task automatic t_rerst();
        @(posedge clk);
        rst <= 1'b1;
        opMode <= MODE_SINGLE;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(32'({padOe, padPullup, 7'h0, padReducedDrive}), 32'h0);
        rd(OFF_DIR, 32'h0, RESP_OKAY);
        rd(OFF_DRIVE, 32'h0, RESP_OKAY);
        wr(OFF_DRIVE, 32'h1, RESP_OKAY);
        rd(OFF_DRIVE, 32'h1, RESP_OKAY);
        @(posedge clk);
        ce <= 1'b0;
        opMode <= MODE_EXPANDED;
        repeat (2) @(negedge clk);
        chk(32'({padOe, s_axi_awready, s_axi_arready}), 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        opMode <= MODE_SINGLE;
    endtask : t_rerst

    initial begin
        #100us;
        n_errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_gpio();
        t_exp();
        t_drive();
        t_rerst();
        results();
    end
endmodule : testbench
`default_nettype wire
